// *** src/dgp_map.svh ***
// offsets, field positions, reset values and timing counts of the dual game port
// assumes inclusion by bare name from the design and bench files
`ifndef DGP_MAP_SVH
`define DGP_MAP_SVH

`define DGP_STATE_OFS 16'h0000
`define DGP_STATE_RST 8'h00
`define DGP_AXIS_LSB 0
`define DGP_BTN_LSB 4

`define DGP_CFG_BASE_HI_IDX 8'h60
`define DGP_CFG_BASE_LO_IDX 8'h61
`define DGP_CFG_ACT_IDX 8'h30
`define DGP_CFG_PWR_IDX 8'h22
`define DGP_ACT_BIT 0
`define DGP_PWR_BIT 2
`define DGP_BASE_RST 16'h0000

`define DGP_CLK_HZ 20000000
`define DGP_DISCH_NS 1000
`define DGP_DISCH_CYC ((`DGP_DISCH_NS * (`DGP_CLK_HZ / 1000000) + 999) / 1000)

`endif

// *** src/dgp_pkg.sv ***
// types of the dual game port readout
// assumes dgp_map.svh supplies the numeric constants
package dgp_pkg;

  typedef enum logic [2:0] {
    DGP_AX_IDLE   = 3'b001,
    DGP_AX_DISCH  = 3'b010,
    DGP_AX_CHARGE = 3'b100
  } dgp_axis_st_t;

endpackage : dgp_pkg

// *** src/dgp_readout.sv ***
// dual game port readout: four one-shot axis timers, four buttons, one read register
// assumes io and config strobes are synchronous to clk and held for at least one cycle
// Operation
// - One 8-bit read-only game port register sits at offset zero of the base and resets to zero.
// - Bits 0 to 3 carry the four axis timer outputs and bits 4 to 7 the four buttons.
// - A write to the game port stores nothing and instead discharges all RC pins to start timing.
// - The discharge begins when the write strobe goes from active back to inactive.
// - Read and write strobes are generated for io reads and writes at the programmed base.
// - The 16-bit base is held in config index game_base_high for the high byte and game_base_low for the low byte.
// - With the activate bit clear the base is not decoded and host accesses are ignored.
// - Power control bit 2 mirrors the activate bit, writing either one updates both.
// - Each axis output stays high from the write until its RC input crosses two thirds, then drops and the pin is held low.
// - Two independent ports, each with two axis timers and two buttons, share one register.
`timescale 1ns/10ps
`default_nettype none
`include "dgp_map.svh"

// one axis: fixed discharge time, then time the charge up to the comparator
module dgp_axis_timer #(
  parameter int DISCH_CYC = `DGP_DISCH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic above_thr,
  output logic timing,
  output logic pin_oe
);

  localparam int CW = (DISCH_CYC > 1) ? $clog2(DISCH_CYC + 1) : 1;
  localparam logic [CW-1:0] DISCH_LAST = CW'(DISCH_CYC - 1);

  dgp_pkg::dgp_axis_st_t st_reg;
  dgp_pkg::dgp_axis_st_t st_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      dgp_pkg::DGP_AX_IDLE: begin
        cnt_next = '0;
      end
      dgp_pkg::DGP_AX_DISCH: begin
        // comparator ignored while the cap is still being emptied
        if (cnt_reg == DISCH_LAST) begin
          st_next = dgp_pkg::DGP_AX_CHARGE;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      dgp_pkg::DGP_AX_CHARGE: begin
        if (above_thr) begin
          st_next = dgp_pkg::DGP_AX_IDLE;
        end
      end
      default: begin
        st_next = dgp_pkg::DGP_AX_IDLE;
        cnt_next = '0;
      end
    endcase
    if (start) begin
      st_next = dgp_pkg::DGP_AX_DISCH;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_reg <= dgp_pkg::DGP_AX_IDLE;
      cnt_reg <= '0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
    end
  end

  assign timing = (st_reg != dgp_pkg::DGP_AX_IDLE);
  // pin pulled low except while charging
  assign pin_oe = (st_reg != dgp_pkg::DGP_AX_CHARGE);

endmodule : dgp_axis_timer

module dgp_readout #(
  parameter int DISCH_CYC = `DGP_DISCH_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [15:0] io_addr,
  input wire logic io_rd,
  input wire logic io_wr,
  output logic [7:0] io_rdata,
  output logic stick_read_strobe,
  output logic stick_write_strobe,
  input wire logic [7:0] cfg_index,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic stick1_x_above_thr,
  input wire logic stick1_y_above_thr,
  input wire logic stick2_x_above_thr,
  input wire logic stick2_y_above_thr,
  output logic stick1_x_rc_pin_out,
  output logic stick1_x_rc_pin_oe,
  output logic stick1_y_rc_pin_out,
  output logic stick1_y_rc_pin_oe,
  output logic stick2_x_rc_pin_out,
  output logic stick2_x_rc_pin_oe,
  output logic stick2_y_rc_pin_out,
  output logic stick2_y_rc_pin_oe,
  input wire logic stick1_button1,
  input wire logic stick1_button2,
  input wire logic stick2_button1,
  input wire logic stick2_button2,
  output logic stick1_x_timer_out,
  output logic stick1_y_timer_out,
  output logic stick2_x_timer_out,
  output logic stick2_y_timer_out
);

  // configuration state
  logic [15:0] base_reg;
  logic [15:0] base_next;
  logic act_reg;
  logic act_next;
  logic [7:0] cfg_rdata_reg;
  logic [7:0] cfg_rdata_next;

  // io decode and read path
  logic hit;
  logic wr_hit_reg;
  logic wr_hit_next;
  logic start_pulse;
  logic [7:0] io_rdata_reg;
  logic [7:0] io_rdata_next;
  logic [3:0] btn_reg;
  logic [3:0] btn_next;
  logic [7:0] state_word;

  // per-axis vectors, index 0..3 = x1, y1, x2, y2
  logic [3:0] ax_out;
  logic [3:0] ax_oe;

  assign hit = act_reg && (io_addr == base_reg + `DGP_STATE_OFS);

  assign stick_read_strobe = io_rd && hit;
  assign stick_write_strobe = io_wr && hit;

  assign start_pulse = wr_hit_reg && !io_wr;

  assign state_word = {btn_reg, ax_out};

  always_comb begin
    base_next = base_reg;
    act_next = act_reg;
    cfg_rdata_next = cfg_rdata_reg;
    if (cfg_wr) begin
      case (cfg_index)
        `DGP_CFG_BASE_HI_IDX: begin
          base_next[15:8] = cfg_wdata;
        end
        `DGP_CFG_BASE_LO_IDX: begin
          base_next[7:0] = cfg_wdata;
        end
        // either bit writes the one flop
        `DGP_CFG_ACT_IDX: begin
          act_next = cfg_wdata[`DGP_ACT_BIT];
        end
        `DGP_CFG_PWR_IDX: begin
          act_next = cfg_wdata[`DGP_PWR_BIT];
        end
        default: begin
          act_next = act_reg;
        end
      endcase
    end
    if (cfg_rd) begin
      cfg_rdata_next = 8'h00;
      case (cfg_index)
        `DGP_CFG_BASE_HI_IDX: begin
          cfg_rdata_next = base_reg[15:8];
        end
        `DGP_CFG_BASE_LO_IDX: begin
          cfg_rdata_next = base_reg[7:0];
        end
        `DGP_CFG_ACT_IDX: begin
          cfg_rdata_next[`DGP_ACT_BIT] = act_reg;
        end
        `DGP_CFG_PWR_IDX: begin
          cfg_rdata_next[`DGP_PWR_BIT] = act_reg;
        end
        default: begin
          cfg_rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      base_reg <= `DGP_BASE_RST;
      act_reg <= 1'b0;
      cfg_rdata_reg <= 8'h00;
    end else begin
      base_reg <= base_next;
      act_reg <= act_next;
      cfg_rdata_reg <= cfg_rdata_next;
    end
  end

  always_comb begin
    // hit is remembered so a base or address change at strobe end cannot lose the start
    wr_hit_next = io_wr && hit;
    btn_next = {stick2_button2, stick2_button1, stick1_button2, stick1_button1};
    io_rdata_next = io_rdata_reg;
    // read-only word, writes leave it alone
    if (stick_read_strobe) begin
      io_rdata_next = state_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_hit_reg <= 1'b0;
      btn_reg <= 4'h0;
      io_rdata_reg <= `DGP_STATE_RST;
    end else begin
      wr_hit_reg <= wr_hit_next;
      btn_reg <= btn_next;
      io_rdata_reg <= io_rdata_next;
    end
  end

  // one timer per axis, all started together
  dgp_axis_timer #(
    .DISCH_CYC(DISCH_CYC)
  ) dgp_axis_timer_x1_i (
    .clk(clk),
    .rst_b(rst_b),
    .start(start_pulse),
    .above_thr(stick1_x_above_thr),
    .timing(ax_out[0]),
    .pin_oe(ax_oe[0])
  );

  dgp_axis_timer #(
    .DISCH_CYC(DISCH_CYC)
  ) dgp_axis_timer_y1_i (
    .clk(clk),
    .rst_b(rst_b),
    .start(start_pulse),
    .above_thr(stick1_y_above_thr),
    .timing(ax_out[1]),
    .pin_oe(ax_oe[1])
  );

  dgp_axis_timer #(
    .DISCH_CYC(DISCH_CYC)
  ) dgp_axis_timer_x2_i (
    .clk(clk),
    .rst_b(rst_b),
    .start(start_pulse),
    .above_thr(stick2_x_above_thr),
    .timing(ax_out[2]),
    .pin_oe(ax_oe[2])
  );

  dgp_axis_timer #(
    .DISCH_CYC(DISCH_CYC)
  ) dgp_axis_timer_y2_i (
    .clk(clk),
    .rst_b(rst_b),
    .start(start_pulse),
    .above_thr(stick2_y_above_thr),
    .timing(ax_out[3]),
    .pin_oe(ax_oe[3])
  );

  assign io_rdata = io_rdata_reg;
  assign cfg_rdata = cfg_rdata_reg;

  assign stick1_x_timer_out = ax_out[0];
  assign stick1_y_timer_out = ax_out[1];
  assign stick2_x_timer_out = ax_out[2];
  assign stick2_y_timer_out = ax_out[3];

  // open-drain discharge: only ever drives zero
  assign stick1_x_rc_pin_out = 1'b0;
  assign stick1_y_rc_pin_out = 1'b0;
  assign stick2_x_rc_pin_out = 1'b0;
  assign stick2_y_rc_pin_out = 1'b0;
  assign stick1_x_rc_pin_oe = ax_oe[0];
  assign stick1_y_rc_pin_oe = ax_oe[1];
  assign stick2_x_rc_pin_oe = ax_oe[2];
  assign stick2_y_rc_pin_oe = ax_oe[3];

endmodule : dgp_readout
`default_nettype wire

// *** sim/dgp_rc_model.sv ***
// rc network and 2/3 comparator of the four game port axes
// assumes oe high means the design holds the rc pin low
`timescale 1ns/10ps
`default_nettype none
module dgp_rc_model (
  input wire logic clk,
  input wire logic [3:0] disch,
  output logic [3:0] above_thr
);
  logic [7:0] cnt [4];
  always_ff @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (disch[i]) begin
        cnt[i] <= 8'h00;
      end else if (cnt[i] != 8'hFF) begin
        cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      above_thr[i] = cnt[i] >= 8'(10 + 30 * i);
    end
  end
endmodule : dgp_rc_model
`default_nettype wire

// *** sim/dgp_readout_asserts.sv ***
// port assertions of the dual game port readout
// assumes bind to dgp_readout, one clock, sync active low reset
`timescale 1ns/10ps
`default_nettype none
module dgp_readout_asserts (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [7:0] io_rdata,
  input wire logic stick_read_strobe,
  input wire logic stick_write_strobe,
  input wire logic stick1_x_above_thr,
  input wire logic stick1_x_rc_pin_oe,
  input wire logic stick2_y_rc_pin_oe,
  input wire logic stick1_x_timer_out,
  input wire logic stick2_y_timer_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence wr_end_s; stick_write_strobe ##1 !io_wr; endsequence
  sequence hit_s; stick1_x_timer_out && !stick1_x_rc_pin_oe && stick1_x_above_thr; endsequence
  a_rd_cause: assert property (stick_read_strobe |-> io_rd)
    else $error("read strobe without read");
  a_wr_cause: assert property (stick_write_strobe |-> io_wr)
    else $error("write strobe without write");
  a_axis_bits: assert property (stick_read_strobe |=>
    {io_rdata[3], io_rdata[0]} == $past({stick2_y_timer_out, stick1_x_timer_out}))
    else $error("axis bits wrong");
  a_rdata_hold: assert property (!stick_read_strobe |=> $stable(io_rdata))
    else $error("read data changed");
  a_write_start: assert property (wr_end_s |=> stick1_x_timer_out && stick2_y_rc_pin_oe)
    else $error("no start after write");
  a_start_late: assert property ($rose(stick2_y_timer_out) |->
    !$past(io_wr) && $past(stick_write_strobe, 2)) else $error("start not at strobe end");
  a_thr_stop: assert property (hit_s ##0 !$past(stick_write_strobe) |=>
    !stick1_x_timer_out && stick1_x_rc_pin_oe) else $error("axis not stopped");
  a_idle_held: assert property (!stick2_y_timer_out |-> stick2_y_rc_pin_oe)
    else $error("idle pin released");
endmodule : dgp_readout_asserts
bind dgp_readout dgp_readout_asserts dgp_readout_asserts_i (.*);
`default_nettype wire

// *** sim/dual_game_port_readout_test.sv ***
// bench: config and io host, rc partner, queued read checks
// assumes dgp_rc_model on the far side and the checker bound by its file
`timescale 1ns/10ps
`default_nettype none
module dual_game_port_readout_test;
  logic clk = 1'b0, rst_b = 1'b0, io_rd = 1'b0, io_wr = 1'b0, cfg_rd = 1'b0, cfg_wr = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] cfg_index = 8'h00, cfg_wdata = 8'h00, q[$];
  logic [3:0] btn = 4'h0;
  logic rdf = 1'b0, cdf = 1'b0;
  int err_count = 0, n_tests = 0, seed = 62461;
  wire [7:0] io_rdata, cfg_rdata;
  wire stick_read_strobe, stick_write_strobe, stick1_x_above_thr, stick1_y_above_thr;
  wire stick2_x_above_thr, stick2_y_above_thr, stick1_x_rc_pin_oe, stick1_y_rc_pin_oe;
  wire stick2_x_rc_pin_oe, stick2_y_rc_pin_oe, stick1_button1 = btn[0];
  wire stick1_button2 = btn[1], stick2_button1 = btn[2], stick2_button2 = btn[3];
  dgp_readout #(.DISCH_CYC(2)) dgp_readout_i (.stick1_x_rc_pin_out(), .stick1_y_rc_pin_out(),
    .stick2_x_rc_pin_out(), .stick2_y_rc_pin_out(), .stick1_x_timer_out(), .stick1_y_timer_out(),
    .stick2_x_timer_out(), .stick2_y_timer_out(), .*);
  dgp_rc_model dgp_rc_model_i (.clk(clk), .disch({stick2_y_rc_pin_oe, stick2_x_rc_pin_oe,
    stick1_y_rc_pin_oe, stick1_x_rc_pin_oe}), .above_thr({stick2_y_above_thr,
    stick2_x_above_thr, stick1_y_above_thr, stick1_x_above_thr}));
  always #25 clk = ~clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rq(input bit io, input logic [7:0] idx, input logic [7:0] exp);
    @(posedge clk) #1;
    cfg_index = idx;
    io_rd = io;
    cfg_rd = !io;
    q.push_back(exp);
    @(posedge clk) #1;
    io_rd = 1'b0;
    cfg_rd = 1'b0;
  endtask : rq
  task automatic cw(input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk) #1;
    cfg_index = idx;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(posedge clk) #1;
    cfg_wr = 1'b0;
  endtask : cw
  // reads then writes where no decode may happen
  task automatic miss();
    for (int i = 0; i < 2; i++) begin
      @(posedge clk) #1;
      {io_wr, io_rd} = 2'(i + 1);
      #5 chk({6'h00, stick_read_strobe, stick_write_strobe}, 8'h00);
    end
    @(posedge clk) #1;
    io_wr = 1'b0;
  endtask : miss
  // write held two cycles, so start must wait for its fall
  task automatic meas();
    btn = 4'($random(seed));
    @(posedge clk) #1;
    io_wr = 1'b1;
    @(posedge clk) #1;
    @(posedge clk) #1;
    io_wr = 1'b0;
    rq(1, 8'h00, {btn, 4'hF});
    repeat (45) @(posedge clk);
    #1 btn = 4'($random(seed));
    repeat (2) @(posedge clk);
    rq(1, 8'h00, {btn, 4'hC});
    repeat (120) @(posedge clk);
    rq(1, 8'h00, {btn, 4'h0});
  endtask : meas
  always @(negedge clk) begin
    if (rdf) chk(io_rdata, q.pop_front());
    if (cdf) chk(cfg_rdata, q.pop_front());
    rdf = stick_read_strobe;
    cdf = cfg_rd;
  end
  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict
  // run needs under 600 cycles, allow several times that
  initial begin
    #200000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rst_b = 1'b1;
    rq(0, 8'h60, 8'h00);
    rq(0, 8'h22, 8'h00);
    miss();
    cw(8'h60, 8'h12);
    cw(8'h61, 8'h34);
    rq(0, 8'h60, 8'h12);
    rq(0, 8'h61, 8'h34);
    rq(0, 8'h5A, 8'h00);
    cw(8'h22, 8'hFF);
    rq(0, 8'h30, 8'h01);
    cw(8'h30, 8'h00);
    rq(0, 8'h22, 8'h00);
    cw(8'h30, 8'h01);
    rq(0, 8'h22, 8'h04);
    io_addr = 16'h1235;
    miss();
    io_addr = 16'h1234;
    rq(1, 8'h00, {btn, 4'h0});
    repeat (2) meas();
    give_verdict();
  end
endmodule : dual_game_port_readout_test
`default_nettype wire
